// *** inc/sdg_pkg.sv ***
// constants, register map and types of the dram command sequencer
// assumes one dram rank on the command pins, one software port
package sdg_pkg;
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_BANK = 4'h2;
  localparam logic [3:0] REG_CFG = 4'h3;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [1:0] REG_LOG_HI = 2'h2;
  localparam int CFG_PRE2 = 0;
  localparam int CFG_TRAIN = 1;
  localparam int CFG_WANT2N = 2;
  localparam int CFG_CL_LSB = 4;
  localparam int CFG_CWL_LSB = 12;
  localparam int STAT_BUSY = 0;
  localparam int STAT_GEAR2N = 1;
  localparam int STAT_REFUSED = 2;
  localparam int STAT_IN_SR = 3;
  localparam int STAT_MPR = 4;
  localparam int STAT_ABORT = 5;
  localparam logic [4:0] CL_RST = 5'h0a;
  localparam logic [4:0] CWL_RST = 5'h08;
  localparam logic [2:0] MR_THREE = 3'h3;
  localparam logic [2:0] MR_FOUR = 3'h4;
  localparam logic [2:0] MR_GEAR = 3'h3;
  localparam int MPR_EN_BIT = 2;
  localparam int ABORT_BIT = 9;
  localparam int GEAR_BIT = 3;
  localparam int AP_BIT = 10;
  localparam logic [1:0] LOG_PAGE_BA = 2'h1;
  localparam logic [1:0] LOC_BANK = 2'h2;
  localparam logic [1:0] LOC_STAT = 2'h3;
  localparam logic [7:0] MASK_NO_A17 = 8'hfd;
  localparam logic [7:0] MASK_MONO = 8'hf8;
  // {ras_n, cas_n, we_n} on address bits 16..14
  localparam logic [2:0] RCW_RD = 3'h5;
  localparam logic [2:0] RCW_WR = 3'h4;
  localparam logic [2:0] RCW_PRE = 3'h2;
  localparam logic [2:0] RCW_MRS = 3'h0;
  localparam logic [2:0] RCW_REF = 3'h1;
  localparam logic [2:0] RCW_NOP = 3'h7;
  // all times in dram clocks (nCK)
  localparam logic [7:0] T_CCD_S = 8'h04;
  localparam logic [7:0] T_CCD_L = 8'h06;
  localparam logic [7:0] T_RRD_S = 8'h04;
  localparam logic [7:0] T_RRD_L = 8'h06;
  localparam logic [7:0] T_FAW = 8'h14;
  localparam logic [7:0] T_WTR_S = 8'h02;
  localparam logic [7:0] T_WTR_L = 8'h06;
  localparam logic [7:0] T_RP = 8'h0c;
  localparam logic [7:0] T_BL_HALF = 8'h04;
  localparam logic [7:0] T_SYNC_GAP = 8'h08;
  localparam logic [7:0] T_CMD_GEAR = 8'h08;
  localparam logic [7:0] T_GEAR_HOLD = 8'h04;
  localparam logic [7:0] T_XS = 8'h18;
  localparam logic [7:0] T_XS_ABORT = 8'h10;
  localparam logic [7:0] T_CAPT_EXTRA = 8'h01;
  typedef enum logic [3:0] {
    OP_NOP, OP_ACT, OP_RD, OP_WR, OP_PRE, OP_PREA,
    OP_MRS, OP_SRE, OP_SRX, OP_GEAR, OP_LOG
  } sdg_op_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_DRIVE, ST_SYNC, ST_ENGAGE, ST_EXIT, ST_CAPT
  } sdg_st_t;
endpackage

// *** design/sdg_ctrl.sv ***
// dram command sequencer: software orders in, dram command pins out
// assumes the dram samples the pins on rising edges of dr_ck
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////
module sdg_ctrl
  import sdg_pkg::*;
#(
  parameter logic [7:0] CCD_S = T_CCD_S,
  parameter logic [7:0] CCD_L = T_CCD_L,
  parameter logic [7:0] RRD_S = T_RRD_S,
  parameter logic [7:0] RRD_L = T_RRD_L,
  parameter logic [7:0] FAW = T_FAW,
  parameter logic [7:0] WTR_S = T_WTR_S,
  parameter logic [7:0] WTR_L = T_WTR_L,
  parameter logic [7:0] RP = T_RP,
  parameter logic [7:0] SYNC_GAP = T_SYNC_GAP,
  parameter logic [7:0] CMD_GEAR = T_CMD_GEAR,
  parameter logic [7:0] XS = T_XS,
  parameter logic [7:0] XS_ABORT = T_XS_ABORT,
  parameter bit HAS_A17 = 1'b1,
  parameter bit MONO = 1'b1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // software port
  input wire logic [3:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [31:0] sw_rdata,
  // dram pins
  output logic dr_ck,
  output logic dr_reset_n,
  output logic dr_cke,
  output logic dr_cs_n,
  output logic dr_act_n,
  output logic [1:0] dr_bg,
  output logic [1:0] dr_ba,
  output logic [17:0] dr_a,
  input wire logic [7:0] dr_dq_in
);

  function automatic logic [7:0] sinc(input logic [7:0] v);
    return (v == 8'hff) ? v : v + 8'h01;
  endfunction

  function automatic logic is_rd(input sdg_op_t o);
    return (o == OP_RD) || (o == OP_LOG);
  endfunction

  function automatic logic is_col(input sdg_op_t o);
    return is_rd(o) || (o == OP_WR);
  endfunction

  sdg_st_t st_r, post_r, pst;
  sdg_op_t op_r, lop;
  logic ck_r, tk, pend_r, refused_r;
  logic pre2_r, train_r, want2n_r;
  logic [4:0] cl_r, cwl_r;
  logic [17:0] addr_r;
  logic [3:0] bank_r;
  logic [7:0] hold_r, wt_r, hl, cap_need, wtr_need;
  logic [7:0] col_since_r, act_since_r, wr_since_r, gear_since_r;
  logic [1:0] col_bg_r, act_bg_r, wr_bg_r;
  logic [15:0] open_r;
  logic [7:0] rp_r [16];
  logic [7:0] faw_r [4];
  logic [1:0] faw_pick;
  logic faw_ok, col_ok, wtr_ok, rrd_ok, bad, ok, lch;
  logic exit_done, cap_done, gear2n_r, in_sr_r;
  logic mpr_en_r, abort_r;
  logic [7:0] dq_m_r, dq_s_r;
  logic [7:0] log_r [4];
  logic l_act_n;
  logic [17:0] l_a;
  logic [3:0] l_bank;
  logic busy;

  ////////////////////////////////////////////////////////////////////
  // dram clock from a divide-by-two; pins move at its falling edge
  always_ff @(posedge sys_clk) begin
    if (reset) ck_r <= 1'b0;
    else ck_r <= ~ck_r;
  end
  assign dr_ck = ck_r;
  assign tk = ck_r;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      dq_m_r <= 8'h00;
      dq_s_r <= 8'h00;
    end else begin
      dq_m_r <= dr_dq_in;
      dq_s_r <= dq_m_r;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // software registers
  assign busy = pend_r || (st_r != ST_IDLE);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      addr_r <= 18'h0_0000;
      bank_r <= 4'h0;
      pre2_r <= 1'b0;
      train_r <= 1'b0;
      want2n_r <= 1'b0;
      cl_r <= CL_RST;
      cwl_r <= CWL_RST;
    end else if (sw_wr) begin
      case (sw_addr)
        REG_ADDR: addr_r <= sw_wdata[17:0];
        REG_BANK: bank_r <= sw_wdata[3:0];
        REG_CFG: begin
          pre2_r <= sw_wdata[CFG_PRE2];
          train_r <= sw_wdata[CFG_TRAIN];
          want2n_r <= sw_wdata[CFG_WANT2N];
          cl_r <= sw_wdata[CFG_CL_LSB +: 5];
          cwl_r <= sw_wdata[CFG_CWL_LSB +: 5];
        end
        default: ;
      endcase
    end
  end

  // an order written while busy is dropped and flagged
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pend_r <= 1'b0;
      op_r <= OP_NOP;
    end else if (sw_wr && sw_addr == REG_CMD && !busy) begin
      pend_r <= 1'b1;
      op_r <= sdg_op_t'(sw_wdata[3:0]);
    end else if (tk && st_r == ST_IDLE && pend_r && (bad || ok)) begin
      pend_r <= 1'b0;
    end
  end

  // set beats a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (reset) refused_r <= 1'b0;
    else if ((sw_wr && sw_addr == REG_CMD && busy)
             || (tk && st_r == ST_IDLE && pend_r && bad)) refused_r <= 1'b1;
    else if (sw_wr && sw_addr == REG_STAT && sw_wdata[STAT_REFUSED])
      refused_r <= 1'b0;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) sw_rdata <= 32'h0000_0000;
    else if (!sw_rd) sw_rdata <= 32'h0000_0000;
    else if (sw_addr[3:2] == REG_LOG_HI)
      sw_rdata <= {24'h00_0000, log_r[sw_addr[1:0]]};
    else begin
      case (sw_addr)
        REG_ADDR: sw_rdata <= {14'h0000, addr_r};
        REG_BANK: sw_rdata <= {28'h000_0000, bank_r};
        REG_CFG: sw_rdata <= {15'h0000, cwl_r, 3'h0, cl_r, 1'b0,
                              want2n_r, train_r, pre2_r};
        REG_STAT: sw_rdata <= {26'h000_0000, abort_r, mpr_en_r,
                               in_sr_r, refused_r, gear2n_r, busy};
        default: sw_rdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // admission checks for the pending order
  always_comb begin
    faw_pick = 2'h0;
    faw_ok = 1'b0;
    for (int i = 3; i >= 0; i--) begin
      if (faw_r[i] == 8'h00) begin
        faw_pick = i[1:0];
        faw_ok = 1'b1;
      end
    end
  end

  always_comb begin
    col_ok = col_since_r >= ((bank_r[3:2] == col_bg_r) ? CCD_L : CCD_S);
    // internal write starts after write latency plus burst
    wtr_need = {3'h0, cwl_r} + {7'h00, pre2_r} + T_BL_HALF
             + ((bank_r[3:2] == wr_bg_r) ? WTR_L : WTR_S)
             + {7'h00, pre2_r};
    wtr_ok = wr_since_r >= wtr_need;
    rrd_ok = act_since_r >= ((bank_r[3:2] == act_bg_r) ? RRD_L : RRD_S);
    bad = 1'b0;
    ok = 1'b1;
    if (in_sr_r && op_r != OP_SRX) bad = 1'b1;
    case (op_r)
      OP_RD: begin
        bad = bad || !open_r[bank_r] || train_r;
        ok = col_ok && wtr_ok;
      end
      OP_WR: begin
        bad = bad || !open_r[bank_r];
        ok = col_ok && !(pre2_r && wr_since_r == 8'h05);
      end
      OP_LOG: begin
        bad = bad || !mpr_en_r || train_r;
        ok = col_ok && wtr_ok;
      end
      OP_ACT: begin
        bad = bad || open_r[bank_r];
        ok = rrd_ok && faw_ok && rp_r[bank_r] == 8'h00;
      end
      OP_GEAR: bad = bad || cl_r[0] || cwl_r[0];
      OP_SRX: bad = !in_sr_r;
      default: ;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // launch: the tick on which the pins load and chip select goes low, except for self refresh exit, which keeps it high
  always_comb begin
    lch = 1'b0;
    lop = op_r;
    case (st_r)
      ST_IDLE: lch = tk && pend_r && !bad && ok;
      ST_SYNC: begin
        lop = OP_NOP;
        lch = tk && gear_since_r == SYNC_GAP;
      end
      ST_EXIT: begin
        lop = OP_GEAR;
        lch = tk && exit_done && want2n_r;
      end
      default: ;
    endcase
    // gear command and sync held static, qualified by one select clock
    if (lop == OP_GEAR || st_r == ST_SYNC) hl = T_GEAR_HOLD;
    else hl = gear2n_r ? 8'h02 : 8'h01;
    case (lop)
      OP_GEAR: pst = ST_SYNC;
      OP_LOG: pst = ST_CAPT;
      OP_SRX: pst = ST_EXIT;
      OP_NOP: pst = (st_r == ST_SYNC) ? ST_ENGAGE : ST_IDLE;
      default: pst = ST_IDLE;
    endcase
  end

  always_comb begin
    exit_done = wt_r >= ((abort_r ? XS_ABORT : XS) - 8'h01);
    cap_need = {3'h0, cl_r} + T_CAPT_EXTRA - (gear2n_r ? 8'h01 : 8'h00);
    cap_done = tk && st_r == ST_CAPT && wt_r == cap_need;
  end

  always_comb begin
    l_act_n = 1'b1;
    l_bank = bank_r;
    l_a = {1'b0, RCW_NOP, addr_r[13:0]};
    case (lop)
      OP_ACT: begin
        l_act_n = 1'b0;
        l_a = addr_r;
      end
      OP_RD: l_a = {1'b0, RCW_RD, addr_r[13:0]};
      OP_WR: l_a = {1'b0, RCW_WR, addr_r[13:0]};
      OP_PRE, OP_PREA: begin
        l_a = {1'b0, RCW_PRE, 14'h0000};
        l_a[AP_BIT] = (lop == OP_PREA);
      end
      OP_MRS: l_a = {1'b0, RCW_MRS, addr_r[13:0]};
      OP_GEAR: begin
        l_a = {1'b0, RCW_MRS, 14'h0000};
        l_a[GEAR_BIT] = 1'b1;
        l_bank = {1'b0, MR_GEAR};
      end
      OP_LOG: begin
        l_a = {1'b0, RCW_RD, 12'h000, addr_r[1:0]};
        l_bank = {bank_r[3:2], LOG_PAGE_BA};
      end
      OP_SRE: l_a = {1'b0, RCW_REF, 14'h0000};
      default: ;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_r <= ST_IDLE;
      post_r <= ST_IDLE;
      hold_r <= 8'h00;
      wt_r <= 8'h00;
    end else if (tk) begin
      case (st_r)
        ST_IDLE, ST_SYNC: begin
          if (lch) begin
            post_r <= pst;
            wt_r <= 8'h00;
            if (hl > 8'h01) begin
              st_r <= ST_DRIVE;
              hold_r <= hl - 8'h01;
            end else st_r <= pst;
          end
        end
        ST_DRIVE: begin
          hold_r <= hold_r - 8'h01;
          if (hold_r == 8'h01) begin
            st_r <= post_r;
            wt_r <= 8'h00;
          end
        end
        ST_ENGAGE: begin
          wt_r <= sinc(wt_r);
          if (wt_r == CMD_GEAR - 8'h01) st_r <= ST_IDLE;
        end
        ST_EXIT: begin
          wt_r <= sinc(wt_r);
          if (lch) begin
            st_r <= ST_DRIVE;
            post_r <= pst;
            hold_r <= hl - 8'h01;
          end else if (exit_done) st_r <= ST_IDLE;
        end
        ST_CAPT: begin
          wt_r <= sinc(wt_r);
          if (wt_r == cap_need) st_r <= ST_IDLE;
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pins
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      dr_reset_n <= 1'b0;
      dr_cke <= 1'b0;
      dr_cs_n <= 1'b1;
      dr_act_n <= 1'b1;
      dr_bg <= 2'h0;
      dr_ba <= 2'h0;
      dr_a <= {1'b0, RCW_NOP, 14'h0000};
    end else begin
      dr_reset_n <= 1'b1;
      if (!dr_reset_n) dr_cke <= 1'b1;
      if (tk && lch) begin
        dr_cs_n <= (lop == OP_SRX);
        dr_act_n <= l_act_n;
        dr_a <= l_a;
        dr_bg <= l_bank[3:2];
        dr_ba <= l_bank[1:0];
        if (lop == OP_SRE) dr_cke <= 1'b0;
        if (lop == OP_SRX) dr_cke <= 1'b1;
      end else if (tk) begin
        dr_cs_n <= 1'b1;
        if (st_r == ST_DRIVE && hold_r == 8'h01) begin
          dr_act_n <= 1'b1;
          dr_a[16:14] <= RCW_NOP;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // spacing counters in dram clocks since the last launch of their kind; such a launch loads
  // one, so at the next tick each counter reads the true launch-to-launch gap
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      col_since_r <= 8'hff;
      act_since_r <= 8'hff;
      wr_since_r <= 8'hff;
      gear_since_r <= 8'h00;
      col_bg_r <= 2'h0;
      act_bg_r <= 2'h0;
      wr_bg_r <= 2'h0;
    end else if (tk) begin
      col_since_r <= (lch && is_col(lop)) ? 8'h01 : sinc(col_since_r);
      act_since_r <= (lch && lop == OP_ACT) ? 8'h01 : sinc(act_since_r);
      wr_since_r <= (lch && lop == OP_WR) ? 8'h01 : sinc(wr_since_r);
      gear_since_r <= (lch && lop == OP_GEAR) ? 8'h01 : sinc(gear_since_r);
      if (lch && is_col(lop)) col_bg_r <= bank_r[3:2];
      if (lch && lop == OP_ACT) act_bg_r <= bank_r[3:2];
      if (lch && lop == OP_WR) wr_bg_r <= bank_r[3:2];
    end
  end

  // a window slot frees itself after the four-activate window
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      for (int i = 0; i < 4; i++) faw_r[i] <= 8'h00;
    end else if (tk) begin
      for (int i = 0; i < 4; i++) begin
        if (lch && lop == OP_ACT && faw_pick == i[1:0]) faw_r[i] <= FAW;
        else if (faw_r[i] != 8'h00) faw_r[i] <= faw_r[i] - 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // bank state; a repeated precharge restarts the row close time
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      open_r <= 16'h0000;
      for (int i = 0; i < 16; i++) rp_r[i] <= 8'h00;
    end else if (tk) begin
      for (int i = 0; i < 16; i++) begin
        if (lch && (lop == OP_PREA || (lop == OP_PRE && bank_r == i[3:0]))) begin
          open_r[i] <= 1'b0;
          rp_r[i] <= RP;
        end else begin
          if (rp_r[i] != 8'h00) rp_r[i] <= rp_r[i] - 8'h01;
          if (lch && lop == OP_ACT && bank_r == i[3:0]) open_r[i] <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // mirrored dram modes
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mpr_en_r <= 1'b0;
      abort_r <= 1'b0;
    end else if (tk && lch && lop == OP_MRS) begin
      if (bank_r[2:0] == MR_THREE) mpr_en_r <= addr_r[MPR_EN_BIT];
      if (bank_r[2:0] == MR_FOUR) abort_r <= addr_r[ABORT_BIT];
    end
  end

  // half rate from reset; self refresh drops the dram back to it
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      gear2n_r <= 1'b0;
      in_sr_r <= 1'b0;
    end else if (tk) begin
      if (lch && lop == OP_SRE) begin
        gear2n_r <= 1'b0;
        in_sr_r <= 1'b1;
      end else if (st_r == ST_ENGAGE && wt_r == CMD_GEAR - 8'h01) begin
        gear2n_r <= 1'b1;
      end
      if (lch && lop == OP_SRX) in_sr_r <= 1'b0;
    end
  end

  // don't-care bits are stored as zero
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      for (int i = 0; i < 4; i++) log_r[i] <= 8'h00;
    end else if (cap_done) begin
      case (addr_r[1:0])
        LOC_BANK: log_r[LOC_BANK] <= HAS_A17 ? dq_s_r : (dq_s_r & MASK_NO_A17);
        LOC_STAT: log_r[LOC_STAT] <= MONO ? (dq_s_r & MASK_MONO) : dq_s_r;
        default: log_r[addr_r[1:0]] <= dq_s_r;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_cs_single: assert property ($fell(dr_cs_n) |=> !dr_cs_n ##1 dr_cs_n)
    else $error("chip select low for more than one dram clock");
  a_gear_even: assert property (tk && lch && st_r == ST_SYNC |-> !gear_since_r[0])
    else $error("sync pulse on an odd clock from gear command");
  a_gear_late: assert property ($rose(gear2n_r) |-> $past(st_r, 2) == ST_ENGAGE)
    else $error("quarter rate entered outside gear delay");
  a_rd_open: assert property (tk && lch && lop == OP_RD |-> open_r[bank_r])
    else $error("read to an idle bank");
  a_ccd5_ban: assert property (tk && lch && lop == OP_WR && pre2_r |-> wr_since_r != 8'h05)
    else $error("writes five clocks apart with long preamble");
  a_col_long: assert property (tk && lch && is_col(lop) && bank_r[3:2] == col_bg_r
                               |-> col_since_r >= CCD_L)
    else $error("column commands too close in one group");
  a_act_close: assert property (tk && lch && lop == OP_ACT |-> rp_r[bank_r] == 8'h00)
    else $error("activate before row close time");
  a_log_gate: assert property (st_r == ST_CAPT |-> mpr_en_r && !train_r)
    else $error("log readout without readout mode");
  a_sr_half: assert property (in_sr_r |-> !gear2n_r)
    else $error("quarter rate kept through self refresh");
  a_srx_wait: assert property (tk && lch && st_r == ST_EXIT |-> wt_r >= XS_ABORT - 8'h01)
    else $error("gear command too soon after exit");

  c_gear: cover property ($rose(gear2n_r));
  c_log: cover property (cap_done);
  c_sr: cover property ($rose(in_sr_r) ##[1:200] $fell(in_sr_r));
  c_refuse: cover property ($rose(refused_r));

endmodule
`default_nettype wire

// *** testbench/sdg_dram_model.sv ***
// dram device model: decodes command pins, serves the error log page,
// keeps gear mode and bank state, counts controller spacing faults
// assumes pins stay stable around each rising edge of dr_ck
`timescale 1ns/1ps
`default_nettype none
module sdg_dram_model
  import sdg_pkg::*;
#(
  parameter logic [31:0] LOG_WORD = 32'h5a3c_c3a5
) (
  // dram pins
  input wire logic dr_ck,
  input wire logic dr_reset_n,
  input wire logic dr_cke,
  input wire logic dr_cs_n,
  input wire logic dr_act_n,
  input wire logic [1:0] dr_bg,
  input wire logic [1:0] dr_ba,
  input wire logic [17:0] dr_a,
  output logic [7:0] dr_dq_in,
  // observation
  output logic gear2n,
  output int faults
);
  int t, t_col, t_act, t_mrs, t_en, q_from;
  int t_colg [4];
  int t_actg [4];
  int t_pre [16];
  logic [15:0] open_b;
  logic mpr_on, sync_wait;
  logic [7:0] qbyte;
  logic [3:0] bk;
  logic [2:0] rcw;
  assign bk = {dr_bg, dr_ba};
  assign rcw = dr_a[16:14];
  // outside the answer window the lines toggle, so a stale capture fails
  assign dr_dq_in = (t >= q_from + 4 && t <= q_from + 20) ? qbyte : (t[0] ? 8'h00 : 8'hff);
  // preamble length and half clock postambles live below pin level
  initial begin
    t = 0; t_col = -100; t_act = -100; t_en = -1; q_from = -100; faults = 0;
    // dr_ck stands still during reset, so the reset branch may never run
    gear2n = 1'b0;
    open_b = 16'h0000;
    mpr_on = 1'b0;
    sync_wait = 1'b0;
    qbyte = 8'h00;
    t_mrs = 0;
    foreach (t_pre[i]) t_pre[i] = -100;
    foreach (t_colg[i]) t_colg[i] = -100;
    foreach (t_actg[i]) t_actg[i] = -100;
  end
  ////////////////////////////////////////////////////////////////////
  always @(posedge dr_ck) begin
    t <= t + 1;
    if (!dr_reset_n) begin
      gear2n <= 1'b0;
      open_b <= '0;
      mpr_on <= 1'b0;
      sync_wait <= 1'b0;
    end else begin
      if (t == t_en) gear2n <= 1'b1;
      if (!dr_cke) gear2n <= 1'b0;
      if (!dr_cs_n && !dr_act_n) begin
        if (open_b[bk] || t - t_pre[bk] < T_RP) faults <= faults + 1;
        if (t - t_actg[dr_bg] < T_RRD_L || t - t_act < T_RRD_S) faults <= faults + 1;
        open_b[bk] <= 1'b1;
        t_act <= t;
        t_actg[dr_bg] <= t;
      end else if (!dr_cs_n) begin
        case (rcw)
          RCW_RD, RCW_WR: begin
            if (mpr_on && rcw == RCW_RD && dr_ba == LOG_PAGE_BA) begin
              qbyte <= LOG_WORD[8 * dr_a[1:0] +: 8];
              q_from <= t;
            end else begin
              if (!open_b[bk]) faults <= faults + 1;
              if (t - t_colg[dr_bg] < T_CCD_L || t - t_col < T_CCD_S)
                faults <= faults + 1;
              t_col <= t;
              t_colg[dr_bg] <= t;
            end
          end
          RCW_PRE: begin
            for (int i = 0; i < 16; i++) begin
              if (dr_a[AP_BIT] || i == bk) begin
                open_b[i] <= 1'b0;
                t_pre[i] <= t;
              end
            end
          end
          RCW_MRS: begin
            if ({dr_bg[0], dr_ba} == MR_THREE) begin
              mpr_on <= dr_a[MPR_EN_BIT];
              if (dr_a[GEAR_BIT]) begin
                t_mrs <= t;
                sync_wait <= 1'b1;
              end
            end
          end
          RCW_NOP: begin
            if (sync_wait) begin
              sync_wait <= 1'b0;
              if ((t - t_mrs) % 2 != 0) faults <= faults + 1;
              t_en <= t + T_CMD_GEAR;
            end
          end
          default: ;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// *** testbench/testbench.sv ***
// self-checking bench: register orders through the software port
// assumes the dram model answers the command pins of the sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sdg_pkg::*;
  localparam logic [31:0] LOG_WORD = 32'h5a3c_c3a5;
  logic sys_clk, reset, sw_wr, sw_rd, dr_ck, dr_reset_n, dr_cke, dr_cs_n, dr_act_n, gear2n;
  logic [3:0] sw_addr;
  logic [31:0] sw_wdata, sw_rdata, d, cfg;
  logic [1:0] dr_bg, dr_ba;
  logic [17:0] dr_a;
  logic [7:0] dr_dq_in;
  int n_errors, compares, faults, wt, w_norm;
  sdg_ctrl sdg_ctrl_i (.sys_clk(sys_clk), .reset(reset), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .dr_ck(dr_ck),
    .dr_reset_n(dr_reset_n), .dr_cke(dr_cke), .dr_cs_n(dr_cs_n), .dr_act_n(dr_act_n),
    .dr_bg(dr_bg), .dr_ba(dr_ba), .dr_a(dr_a), .dr_dq_in(dr_dq_in));
  sdg_dram_model #(.LOG_WORD(LOG_WORD)) sdg_dram_model_i (.dr_ck(dr_ck),
    .dr_reset_n(dr_reset_n), .dr_cke(dr_cke), .dr_cs_n(dr_cs_n), .dr_act_n(dr_act_n),
    .dr_bg(dr_bg), .dr_ba(dr_ba), .dr_a(dr_a), .dr_dq_in(dr_dq_in), .gear2n(gear2n),
    .faults(faults));
  ////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (n_errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    sw_wr <= 1'b1;
    sw_addr <= a;
    sw_wdata <= v;
    @(posedge sys_clk);
    sw_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    sw_rd <= 1'b1;
    sw_addr <= a;
    @(posedge sys_clk);
    sw_rd <= 1'b0;
    #1 v = sw_rdata;
  endtask
  task automatic sbit(input int b, input logic v);
    logic [31:0] s;
    rd(REG_STAT, s);
    chk({31'h0, s[b]}, {31'h0, v});
  endtask
  // refused flag is sticky, so each check also clears it
  task automatic refused(input logic v);
    sbit(STAT_REFUSED, v);
    wr(REG_STAT, 32'h0000_0004);
  endtask
  task automatic idle();
    logic [31:0] s;
    wt = 0;
    do begin
      rd(REG_STAT, s);
      wt++;
    end while (s[STAT_BUSY] !== 1'b0 && wt < 300);
    if (wt >= 300) begin
      n_errors++;
      conclude();
    end
  endtask
  task automatic cmd(input sdg_op_t op, input logic [17:0] a, input logic [3:0] b);
    wr(REG_ADDR, {14'h0, a});
    wr(REG_BANK, {28'h0, b});
    wr(REG_CMD, {28'h0, op});
    idle();
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    reset = 1'b1; sw_wr = 1'b0; sw_rd = 1'b0; sw_addr = 4'h0; sw_wdata = 32'h0;
    n_errors = 0; compares = 0;
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    cfg = {15'h0, CWL_RST, 3'h0, CL_RST, 4'h0};
    rd(REG_CFG, d); chk(d, cfg);
    wr(4'h5, 32'hffff_ffff); rd(4'h5, d); chk(d, 32'h0);
    sbit(STAT_GEAR2N, 1'b0); chk({31'h0, gear2n}, 32'h0);
    cmd(OP_RD, 18'h0, 4'h0); refused(1'b1);
    cmd(OP_ACT, 18'h2_a5a5, 4'h0); cmd(OP_ACT, 18'h1_0001, 4'h4);
    cmd(OP_ACT, 18'h3_ffff, 4'h1); refused(1'b0);
    cmd(OP_ACT, 18'h0, 4'h0); refused(1'b1);
    cmd(OP_WR, 18'h0, 4'h0); cmd(OP_RD, 18'h8, 4'h4); cmd(OP_RD, 18'h10, 4'h1);
    cmd(OP_PRE, 18'h0, 4'h0); cmd(OP_PRE, 18'h0, 4'h0); refused(1'b0);
    cmd(OP_ACT, 18'h0_0077, 4'h0); cmd(OP_PREA, 18'h0, 4'h0);
    cmd(OP_LOG, 18'h0, 4'h0); refused(1'b1);
    cmd(OP_MRS, 18'h4, {1'b0, MR_THREE}); sbit(STAT_MPR, 1'b1);
    for (int i = 0; i < 4; i++) begin
      cmd(OP_LOG, 18'(i), 4'h0);
      rd(4'(8 + i), d);
      chk(d, {24'h0, LOG_WORD[8 * i +: 8] & (i == 3 ? MASK_MONO : 8'hff)});
    end
    // training on with readout mode still on: only training can refuse it
    wr(REG_CFG, cfg | 32'h0000_0002); cmd(OP_LOG, 18'h0, 4'h0); refused(1'b1);
    cmd(OP_MRS, 18'h0, {1'b0, MR_THREE});
    wr(REG_CFG, cfg | 32'h0000_0010); cmd(OP_GEAR, 18'h0, 4'h0); refused(1'b1);
    wr(REG_CFG, cfg | 32'h0000_0004); cmd(OP_GEAR, 18'h0, 4'h0); refused(1'b0);
    repeat (20) @(posedge sys_clk);
    sbit(STAT_GEAR2N, 1'b1); chk({31'h0, gear2n}, 32'h1);
    for (int i = 0; i < 2; i++) begin
      cmd(OP_MRS, 18'(i << ABORT_BIT), {1'b0, MR_FOUR}); sbit(STAT_ABORT, 1'(i));
      cmd(OP_SRE, 18'h0, 4'h0); sbit(STAT_IN_SR, 1'b1);
      chk({31'h0, gear2n}, 32'h0);
      cmd(OP_ACT, 18'h0, 4'h0); refused(1'b1);
      cmd(OP_SRX, 18'h0, 4'h0);
      if (i == 0) w_norm = wt;
      else chk({31'h0, wt < w_norm}, 32'h1);
      repeat (20) @(posedge sys_clk);
      sbit(STAT_GEAR2N, 1'b1); chk({31'h0, gear2n}, 32'h1);
    end
    // half rate wanted after exit: no gear command may follow
    wr(REG_CFG, cfg); cmd(OP_SRE, 18'h0, 4'h0); cmd(OP_SRX, 18'h0, 4'h0);
    sbit(STAT_GEAR2N, 1'b0); chk({31'h0, gear2n}, 32'h0);
    cmd(OP_SRX, 18'h0, 4'h0); refused(1'b1);
    chk(32'(faults), 32'h0);
    conclude();
  end
endmodule
`default_nettype wire
